// ### logic/gpio_cfg.svh
// Address map, reset defaults and sizes of the eight-port GPIO bank.
// Assumes inclusion by bare name from the package and the bank top.
`ifndef GPIO_CFG_SVH
`define GPIO_CFG_SVH

// ****************************************
// Sizes
// ****************************************
`define GPIO_PORTS 8
`define GPIO_WIDTH 8
`define GPIO_ALL_PINS 64

// ****************************************
// Register offsets within one port window
// ****************************************
`define GPIO_OFS_DATA 8'h00
`define GPIO_OFS_DIR 8'h04
`define GPIO_OFS_AFSEL 8'h08
`define GPIO_OFS_DEN 8'h0C
`define GPIO_OFS_PUR 8'h10
`define GPIO_OFS_PDR 8'h14
`define GPIO_OFS_PIN 8'h18

// ****************************************
// Port window fields of the byte address
// ****************************************
`define GPIO_PORT_MSB 10
`define GPIO_PORT_LSB 8
`define GPIO_MAP_TOP 11

// ****************************************
// Debug pin defaults
// ****************************************
`define GPIO_IDX_B 3'h1
`define GPIO_IDX_C 3'h2
`define GPIO_DBG_B 8'h80
`define GPIO_DBG_C 8'h0F
`define GPIO_RST_ZERO 8'h00
`define GPIO_TRST_BIT 7
// Synchroniser reset level: port B bit seven idles high on its pull-up
`define GPIO_SYNC_IDLE 64'h0000_0000_0000_8000

`endif

// ### logic/gpio_pkg.sv
// Types shared by the GPIO bank and its helpers.
// Assumes gpio_cfg.svh on the include path.
`include "gpio_cfg.svh"

package gpio_pkg;

  // ****************************************
  // Register select
  // ****************************************
  typedef enum logic [2:0] {
    sel_none = 3'b000,
    sel_data = 3'b001,
    sel_dir = 3'b010,
    sel_afsel = 3'b011,
    sel_den = 3'b100,
    sel_pur = 3'b101,
    sel_pdr = 3'b110,
    sel_pin = 3'b111
  } reg_sel_t;

  // ****************************************
  // Pad and peripheral carriers
  // ****************************************
  typedef struct packed {
    logic [`GPIO_WIDTH-1:0] out;
    logic [`GPIO_WIDTH-1:0] oe;
    logic [`GPIO_WIDTH-1:0] pu;
    logic [`GPIO_WIDTH-1:0] pd;
  } pad_drive_t;

  typedef struct packed {
    logic [`GPIO_WIDTH-1:0] out;
    logic [`GPIO_WIDTH-1:0] oe;
  } periph_t;

endpackage

// ### logic/gpio_pin_sync.sv
// Three-stage synchroniser for every pad input of the bank.
// Assumes raw pads are asynchronous to core_clk.
`timescale 1ns/1ns
`include "gpio_cfg.svh"

module gpio_pin_sync
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Pads in, clean levels out
  input wire logic [`GPIO_ALL_PINS-1:0] raw,
  output logic [`GPIO_ALL_PINS-1:0] clean
);

  logic [`GPIO_ALL_PINS-1:0] ff1;
  logic [`GPIO_ALL_PINS-1:0] ff2;
  logic [`GPIO_ALL_PINS-1:0] ff3;
  logic [`GPIO_ALL_PINS-1:0] next_clean;

  // Accept a change only once stages two and three agree
  always_comb begin
    next_clean = (~(ff2 ^ ff3) & ff3) | ((ff2 ^ ff3) & clean);
  end

  // First stage feeds only the second, to keep metastability contained
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ff1 <= `GPIO_SYNC_IDLE; // Idle levels, so no false test reset follows reset
      ff2 <= `GPIO_SYNC_IDLE;
      ff3 <= `GPIO_SYNC_IDLE;
      clean <= `GPIO_SYNC_IDLE;
    end else begin
      ff1 <= raw;
      ff2 <= ff1;
      ff3 <= ff2;
      clean <= next_clean;
    end
  end

endmodule

// ### logic/gpio_pad_mux.sv
// Pad drive selection for one eight-pin port.
// Assumes registered inputs; the caller registers the result.
`timescale 1ns/1ns
`include "gpio_cfg.svh"

module gpio_pad_mux
  import gpio_pkg::*;
(
  // Port configuration
  input wire logic [`GPIO_WIDTH-1:0] afsel,
  input wire logic [`GPIO_WIDTH-1:0] den,
  input wire logic [`GPIO_WIDTH-1:0] dir,
  input wire logic [`GPIO_WIDTH-1:0] data,
  // Owning peripheral
  input wire periph_t periph,
  // Next pad drive
  output logic [`GPIO_WIDTH-1:0] next_out,
  output logic [`GPIO_WIDTH-1:0] next_oe
);

  // Peripheral owns a pin when selected, else data and direction do;
  // a pad with digital disabled never drives
  always_comb begin
    next_oe = den & ((afsel & periph.oe) | (~afsel & dir));
    next_out = den & ((afsel & periph.out) | (~afsel & data));
  end

endmodule

// ### logic/gpio_bank.sv
// Eight identical GPIO ports behind one APB slave.
// Assumes a single core_clk domain; pads arrive asynchronously.
`timescale 1ns/1ns
`include "gpio_cfg.svh"

// Functional notes
// - After reset ordinary pins are undriven with alternate select, digital enable and pulls all zero.
// - The five debug pins reset with alternate select, digital enable and pull-up set.
// - Power-on reset and external reset both restore these defaults.
// - After reset port B bit seven is the test-reset input and a low on it resets the JTAG controller.
// - There are eight identical ports, each with its own registers and pins.
// - Each pin has its own direction bit.
// - A pin with direction zero is an input and its data bit captures the pad level.
// - A pin with direction one is an output and its data bit drives the pad.
// - With alternate select set the owning peripheral controls the pin, else data and direction do.
// - Digital enable gates each pad's drive and data capture, but not pad_value or the pin status read.
module gpio_bank
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [`GPIO_PORTS-1:0][`GPIO_WIDTH-1:0] pad_in,
  output pad_drive_t [`GPIO_PORTS-1:0] pad_drive,
  // Peripherals
  input wire periph_t [`GPIO_PORTS-1:0] periph,
  output logic [`GPIO_PORTS-1:0][`GPIO_WIDTH-1:0] pad_value,
  output logic jtag_trst_n
);

  // ****************************************
  // Decode helpers
  // ****************************************

  // Register within a port window; sel_none for holes
  function automatic reg_sel_t reg_sel(input logic [11:0] a);
    reg_sel_t s;
    s = sel_none;
    if (a[`GPIO_MAP_TOP]) begin
      s = sel_none;
    end else if (a[7:0] == `GPIO_OFS_DATA) begin
      s = sel_data;
    end else if (a[7:0] == `GPIO_OFS_DIR) begin
      s = sel_dir;
    end else if (a[7:0] == `GPIO_OFS_AFSEL) begin
      s = sel_afsel;
    end else if (a[7:0] == `GPIO_OFS_DEN) begin
      s = sel_den;
    end else if (a[7:0] == `GPIO_OFS_PUR) begin
      s = sel_pur;
    end else if (a[7:0] == `GPIO_OFS_PDR) begin
      s = sel_pdr;
    end else if (a[7:0] == `GPIO_OFS_PIN) begin
      s = sel_pin;
    end
    return s;
  endfunction

  // Reset value of the debug-owned bits of a port
  function automatic logic [7:0] dbg_mask(input logic [2:0] p);
    logic [7:0] m;
    m = `GPIO_RST_ZERO;
    if (p == `GPIO_IDX_B) begin
      m = `GPIO_DBG_B;
    end else if (p == `GPIO_IDX_C) begin
      m = `GPIO_DBG_C;
    end
    return m;
  endfunction

  // ****************************************
  // Storage
  // ****************************************
  logic [7:0] data [`GPIO_PORTS];
  logic [7:0] dir [`GPIO_PORTS];
  logic [7:0] afsel [`GPIO_PORTS];
  logic [7:0] den [`GPIO_PORTS];
  logic [7:0] pur [`GPIO_PORTS];
  logic [7:0] pdr [`GPIO_PORTS];
  logic [7:0] out_q [`GPIO_PORTS];
  logic [7:0] oe_q [`GPIO_PORTS];
  logic [7:0] next_data [`GPIO_PORTS];
  logic [7:0] next_dir [`GPIO_PORTS];
  logic [7:0] next_afsel [`GPIO_PORTS];
  logic [7:0] next_den [`GPIO_PORTS];
  logic [7:0] next_pur [`GPIO_PORTS];
  logic [7:0] next_pdr [`GPIO_PORTS];
  logic [7:0] mux_out [`GPIO_PORTS];
  logic [7:0] mux_oe [`GPIO_PORTS];
  logic [`GPIO_ALL_PINS-1:0] pin_clean;
  logic [7:0] pin_sync [`GPIO_PORTS];
  logic next_trst_n;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  reg_sel_t sel;
  logic [2:0] port;
  logic wr_go;

  // ****************************************
  // Pad input synchroniser
  // ****************************************

  // All pads share one bank of three-stage synchronisers
  gpio_pin_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .raw(pad_in),
    .clean(pin_clean)
  );

  // ****************************************
  // Per-port drive selection
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `GPIO_PORTS; g++) begin : g_port
      // Eight identical copies of the port logic
      gpio_pad_mux u_mux (
        .afsel(afsel[g]),
        .den(den[g]),
        .dir(dir[g]),
        .data(data[g]),
        .periph(periph[g]),
        .next_out(mux_out[g]),
        .next_oe(mux_oe[g])
      );
      assign pin_sync[g] = pin_clean[g*8 +: 8];
      assign pad_drive[g] = '{out: out_q[g], oe: oe_q[g], pu: pur[g], pd: pdr[g]};
      assign pad_value[g] = pin_sync[g];
    end
  endgenerate

  // ****************************************
  // Register next state
  // ****************************************

  // Writes land only at the access edge that sees pready
  assign wr_go = psel & penable & pwrite & pready;
  assign sel = reg_sel(paddr);
  assign port = paddr[`GPIO_PORT_MSB:`GPIO_PORT_LSB];

  always_comb begin
    for (int i = 0; i < `GPIO_PORTS; i++) begin
      next_dir[i] = dir[i];
      next_afsel[i] = afsel[i];
      next_den[i] = den[i];
      next_pur[i] = pur[i];
      next_pdr[i] = pdr[i];
      next_data[i] = data[i];
      if (wr_go && port == 3'(i)) begin
        if (sel == sel_dir) begin
          next_dir[i] = pwdata[7:0];
        end else if (sel == sel_afsel) begin
          next_afsel[i] = pwdata[7:0];
        end else if (sel == sel_den) begin
          next_den[i] = pwdata[7:0];
        end else if (sel == sel_pur) begin
          next_pur[i] = pwdata[7:0];
        end else if (sel == sel_pdr) begin
          next_pdr[i] = pwdata[7:0];
        end else if (sel == sel_data) begin
          next_data[i] = pwdata[7:0];
        end
      end
      // Input bits follow the pad; a digitally disabled input reads zero
      next_data[i] = (dir[i] & next_data[i]) | (~dir[i] & den[i] & pin_sync[i]);
    end
    // Test-reset follows the pin level while the pin is in its debug role
    next_trst_n = ~(afsel[1][`GPIO_TRST_BIT] & den[1][`GPIO_TRST_BIT])
      | pin_sync[1][`GPIO_TRST_BIT];
  end

  // Async reset loads debug defaults on the five shared pins
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `GPIO_PORTS; i++) begin
        data[i] <= `GPIO_RST_ZERO;
        dir[i] <= `GPIO_RST_ZERO;
        afsel[i] <= dbg_mask(3'(i));
        den[i] <= dbg_mask(3'(i));
        pur[i] <= dbg_mask(3'(i));
        pdr[i] <= `GPIO_RST_ZERO;
        out_q[i] <= `GPIO_RST_ZERO;
        oe_q[i] <= `GPIO_RST_ZERO;
      end
      jtag_trst_n <= 1'b1;
    end else begin
      for (int i = 0; i < `GPIO_PORTS; i++) begin
        data[i] <= next_data[i];
        dir[i] <= next_dir[i];
        afsel[i] <= next_afsel[i];
        den[i] <= next_den[i];
        pur[i] <= next_pur[i];
        pdr[i] <= next_pdr[i];
        out_q[i] <= mux_out[i];
        oe_q[i] <= mux_oe[i];
      end
      jtag_trst_n <= next_trst_n;
    end
  end

  // ****************************************
  // APB answer
  // ****************************************

  // Answer is prepared in setup so pready and prdata leave a flop
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (psel && !penable) begin
      next_pready = 1'b1;
      next_pslverr = (sel == sel_none);
      next_prdata = 32'h0000_0000;
      if (!pwrite) begin
        if (sel == sel_data) begin
          next_prdata[7:0] = data[port];
        end else if (sel == sel_dir) begin
          next_prdata[7:0] = dir[port];
        end else if (sel == sel_afsel) begin
          next_prdata[7:0] = afsel[port];
        end else if (sel == sel_den) begin
          next_prdata[7:0] = den[port];
        end else if (sel == sel_pur) begin
          next_prdata[7:0] = pur[port];
        end else if (sel == sel_pdr) begin
          next_prdata[7:0] = pdr[port];
        end else if (sel == sel_pin) begin
          next_prdata[7:0] = pin_sync[port];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic first_cyc;

  // Marks the first edge after reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      first_cyc <= 1'b1;
    end else begin
      first_cyc <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  property p_plain_default;
    first_cyc |-> afsel[0] == 8'h00 && den[3] == 8'h00 && pur[7] == 8'h00 && pad_drive[5].oe == 8'h00;
  endproperty
  a_plain_default: assert property (p_plain_default) else $error("ordinary pin default wrong");

  property p_dbg_default;
    first_cyc |-> afsel[1] == 8'h80 && den[2] == 8'h0F && pur[1] == 8'h80 && pur[2] == 8'h0F;
  endproperty
  a_dbg_default: assert property (p_dbg_default) else $error("debug pin default wrong");

  property p_trst;
    (afsel[1][7] && den[1][7] && !pin_sync[1][7]) |=> !jtag_trst_n;
  endproperty
  a_trst: assert property (p_trst) else $error("test reset not passed on");

  generate
    for (g = 0; g < `GPIO_PORTS; g++) begin : g_chk
      sequence s_dir_wr;
        wr_go && port == 3'(g) && sel == sel_dir;
      endsequence

      property p_dir_wr;
        s_dir_wr |=> dir[g] == $past(pwdata[7:0]);
      endproperty
      a_dir_wr: assert property (p_dir_wr) else $error("direction write lost");

      property p_isolated;
        (wr_go && port != 3'(g)) |=> $stable(dir[g]) && $stable(afsel[g]);
      endproperty
      a_isolated: assert property (p_isolated) else $error("port written by neighbour");

      property p_capture;
        1'b1 |=> ((~$past(dir[g]) & $past(den[g])) & (data[g] ^ $past(pin_sync[g]))) == 8'h00;
      endproperty
      a_capture: assert property (p_capture) else $error("input not captured");

      property p_drive;
        1'b1 |=> (($past(dir[g]) ^ oe_q[g]) & ~$past(afsel[g]) & $past(den[g])) == 8'h00;
      endproperty
      a_drive: assert property (p_drive) else $error("output enable wrong");

      property p_periph;
        1'b1 |=> ((out_q[g] ^ $past(periph[g].out)) & $past(afsel[g]) & $past(den[g])) == 8'h00;
      endproperty
      a_periph: assert property (p_periph) else $error("peripheral not in control");

      property p_den_off;
        1'b1 |=> (oe_q[g] & ~$past(den[g])) == 8'h00 && (out_q[g] & ~$past(den[g])) == 8'h00;
      endproperty
      a_den_off: assert property (p_den_off) else $error("disabled pad drives");

      property p_cleared;
        first_cyc |-> dir[g] == 8'h00 && oe_q[g] == 8'h00;
      endproperty
      a_cleared: assert property (p_cleared) else $error("direction not cleared");
    end
  endgenerate

endmodule

// ### bench/gpio_board.sv
// Board model: the level each pad settles at, given the bank's drive, pulls and outside sources.
// Assumes the bench chooses which pins the board drives and at what level.
`timescale 1ns/1ns
`include "gpio_cfg.svh"

module gpio_board
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Bank drive and board sources
  input wire pad_drive_t [`GPIO_PORTS-1:0] pad_drive,
  input wire logic [`GPIO_PORTS-1:0][`GPIO_WIDTH-1:0] ext_en,
  input wire logic [`GPIO_PORTS-1:0][`GPIO_WIDTH-1:0] ext_val,
  // Pad levels back to the bank
  output logic [`GPIO_PORTS-1:0][`GPIO_WIDTH-1:0] pad_in
);
  logic [7:0] float_pat = 8'h00;

  // Floating pads wander, so a stale level never passes for a read
  always @(posedge core_clk)
    float_pat <= float_pat + 8'h35;

  // Bank drive wins, then the board, then the pulls
  always_comb begin
    for (int p = 0; p < `GPIO_PORTS; p++) begin
      for (int b = 0; b < `GPIO_WIDTH; b++) begin
        if (pad_drive[p].oe[b])
          pad_in[p][b] = pad_drive[p].out[b];
        else if (!nrst && p == `GPIO_IDX_B && b == `GPIO_TRST_BIT)
          pad_in[p][b] = 1'b1;
        else if (ext_en[p][b])
          pad_in[p][b] = ext_val[p][b];
        else if (pad_drive[p].pu[b])
          pad_in[p][b] = 1'b1;
        else if (pad_drive[p].pd[b])
          pad_in[p][b] = 1'b0;
        else
          pad_in[p][b] = float_pat[b];
      end
    end
  end
endmodule

// ### bench/gpio_port_direction_defaults_tb.sv
// Self-checking bench of the GPIO bank: reset defaults, direction, alternate function, enables.
// Assumes the board model in gpio_board.sv; an APB master lives here.
`timescale 1ns/1ns
`include "gpio_cfg.svh"

module gpio_port_direction_defaults_tb
  import gpio_pkg::*;
;
  logic core_clk, nrst, psel, penable, pwrite, pready, pslverr, jtag_trst_n, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [`GPIO_PORTS-1:0][`GPIO_WIDTH-1:0] pad_in, pad_value, ext_en, ext_val;
  pad_drive_t [`GPIO_PORTS-1:0] pad_drive;
  periph_t [`GPIO_PORTS-1:0] periph;
  logic [7:0] r_dir, r_dat, r_ext, r_exp;
  periph_t r_per;
  int n_fail, samples_checked;

  // ****************************************
  // Design and board
  // ****************************************
  gpio_bank dut (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pad_in(pad_in), .pad_drive(pad_drive), .periph(periph), .pad_value(pad_value),
    .jtag_trst_n(jtag_trst_n));
  gpio_board board (.core_clk(core_clk), .nrst(nrst), .pad_drive(pad_drive), .ext_en(ext_en),
    .ext_val(ext_val), .pad_in(pad_in));

  // 20 MHz core clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; an idle cycle always separates two calls
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 16) begin
      n_fail++;
      $display("[FAIL] %0t no APB answer", $time);
      wrap_up();
    end
  endtask

  task automatic wr(input int p, input logic [7:0] ofs, input logic [7:0] v);
    apb(1'b1, {1'b0, p[2:0], ofs}, {24'h0, v});
  endtask

  task automatic rdreg(input int p, input logic [7:0] ofs);
    apb(1'b0, {1'b0, p[2:0], ofs}, 32'h0);
  endtask

  function automatic logic [7:0] dbg(input int p);
    return p == 1 ? `GPIO_DBG_B : (p == 2 ? `GPIO_DBG_C : `GPIO_RST_ZERO);
  endfunction

  // Every port's configuration and pad drive right after reset
  task automatic check_defaults();
    // A stale synchroniser would pulse test reset low just after release
    repeat (2) @(posedge core_clk);
    chk(32'(jtag_trst_n), 32'h1, "trst after reset");
    for (int p = 0; p < `GPIO_PORTS; p++) begin
      rdreg(p, `GPIO_OFS_DIR);
      chk(rd, 32'h0, "dir reset");
      rdreg(p, `GPIO_OFS_AFSEL);
      chk(rd, {24'h0, dbg(p)}, "afsel reset");
      rdreg(p, `GPIO_OFS_DEN);
      chk(rd, {24'h0, dbg(p)}, "den reset");
      rdreg(p, `GPIO_OFS_PUR);
      chk(rd, {24'h0, dbg(p)}, "pur reset");
      rdreg(p, `GPIO_OFS_PDR);
      chk(rd, 32'h0, "pdr reset");
      chk(32'(pad_drive[p].oe), 32'h0, "oe reset");
      chk(32'(pad_drive[p].pu), {24'h0, dbg(p)}, "pu reset");
      chk(32'(pad_drive[p].pd), 32'h0, "pd reset");
    end
    chk(32'(jtag_trst_n), 32'h1, "trst idle");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    periph = '0;
    ext_en = '0;
    ext_val = '0;
    n_fail = 0;
    samples_checked = 0;
    nrst = 1'b0;
    void'($urandom(32'ha2d0));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    check_defaults();
    $display("test reset_defaults done");
    // Test-reset pin follows a low level on the pad in its debug role
    ext_en[1][7] <= 1'b1;
    ext_val[1][7] <= 1'b0;
    repeat (8) @(posedge core_clk);
    chk(32'(jtag_trst_n), 32'h0, "trst low");
    ext_val[1][7] <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(32'(jtag_trst_n), 32'h1, "trst high");
    $display("test test_reset_pin done");
    // Every port, all-input and all-output corners at the ends
    for (int p = 0; p < `GPIO_PORTS; p++) begin
      r_dir = p == 0 ? 8'h00 : (p == 7 ? 8'hFF : 8'($urandom));
      r_dat = 8'($urandom);
      r_ext = 8'($urandom);
      r_per = 16'($urandom);
      r_exp = (r_dat & r_dir) | (r_ext & ~r_dir);
      ext_en[p] <= ~r_dir;
      ext_val[p] <= r_ext;
      wr(p, `GPIO_OFS_AFSEL, 8'h00);
      wr(p, `GPIO_OFS_DEN, 8'hFF);
      wr(p, `GPIO_OFS_DIR, r_dir);
      wr(p, `GPIO_OFS_DATA, r_dat);
      @(posedge core_clk);
      #1;
      chk(32'(pad_drive[p].oe), 32'(r_dir), "oe by dir");
      // Input pins echo their captured level on out; only oe lets it reach the pad
      chk(32'(pad_drive[p].out), 32'(r_exp), "out by data");
      repeat (8) @(posedge core_clk);
      rdreg(p, `GPIO_OFS_DATA);
      chk(rd, 32'(r_exp), "data capture");
      chk(32'(pad_value[p]), 32'(r_exp), "pad level");
      rdreg(p, `GPIO_OFS_PIN);
      chk(rd, 32'(r_exp), "pin status");
      wr(p, `GPIO_OFS_PDR, r_ext);
      #1;
      chk(32'(pad_drive[p].pd), 32'(r_ext), "pd by pdr");
      periph[p] <= r_per;
      wr(p, `GPIO_OFS_AFSEL, 8'hFF);
      @(posedge core_clk);
      #1;
      chk(32'(pad_drive[p].oe), 32'(r_per.oe), "periph oe");
      chk(32'(pad_drive[p].out), 32'(r_per.out), "periph out");
      wr(p, `GPIO_OFS_DEN, 8'h00);
      @(posedge core_clk);
      #1;
      chk(32'(pad_drive[p].oe), 32'h0, "den gates");
    end
    $display("test direction_ports done");
    // Holes refuse; bit eleven must not alias onto a port
    apb(1'b0, 12'h01C, 32'h0);
    chk({31'h0, err}, 32'h1, "hole error");
    apb(1'b1, 12'h804, 32'h0000_00FF);
    chk({31'h0, err}, 32'h1, "high error");
    rdreg(0, `GPIO_OFS_DIR);
    chk(rd, 32'h0, "no alias");
    $display("test unmapped done");
    // Reset again in mid-run; board keeps the test-reset pin high
    periph <= '0;
    ext_en <= '0;
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    check_defaults();
    $display("test second_reset done");
    wrap_up();
  end
endmodule
